// ---- hw/isbc_consts.vh ----
/*
 Constants for the independent sink blink control block: register
 offsets, field positions, reset values and timing counts.
 Assumes a 100 MHz core clock and an 8-bit register port.
*/
`ifndef ISBC_CONSTS_VH
`define ISBC_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ISBC_ADDR_FADE_LAW     8'h0F
`define ISBC_ADDR_SINK_ENABLE  8'h10
`define ISBC_ADDR_TIME_UPPER   8'h11
`define ISBC_ADDR_TIME_LOWER   8'h12

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define ISBC_LAW_MSB           1
`define ISBC_ON_TIME_MSB       7
`define ISBC_ON_TIME_LSB       6
`define ISBC_SINK_COUNT        7
`define ISBC_RESET_VALUE       8'h00

// ----------------------------------------------------------------
// Timing: times in ms, time base tick of 1 ms
// ----------------------------------------------------------------
`define ISBC_CLOCK_HZ          100000000
`define ISBC_TICK_MS           1
`define ISBC_TICK_CYCLES       (`ISBC_CLOCK_HZ / 1000 * `ISBC_TICK_MS)
`define ISBC_ON_MS_0           200
`define ISBC_ON_MS_1           600
`define ISBC_ON_MS_2           800
`define ISBC_ON_MS_3           1200
`define ISBC_OFF_MS_1          600
`define ISBC_OFF_MS_2          1200
`define ISBC_OFF_MS_3          1800

`endif

// ---- hw/isbc_sink_timer.v ----
/*
 One sink's on/off phase timer, counting time base ticks.
 Assumes tick is a one-cycle pulse in the clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "isbc_consts.vh"

module isbc_sink_timer #(
	parameter CNT_W = 11
) (
	input  wire             clock,
	input  wire             reset,
	input  wire             clk_en,
	input  wire             tick,
	input  wire             enable,
	input  wire             restart,
	input  wire [1:0]       on_code,
	input  wire [1:0]       dark_code,
	output reg              lit_r
);

	// ----------------------------------------------------------------
	// Period lookup
	// ----------------------------------------------------------------
	localparam [31:0] ON_T0   = `ISBC_ON_MS_0 / `ISBC_TICK_MS;
	localparam [31:0] ON_T1   = `ISBC_ON_MS_1 / `ISBC_TICK_MS;
	localparam [31:0] ON_T2   = `ISBC_ON_MS_2 / `ISBC_TICK_MS;
	localparam [31:0] ON_T3   = `ISBC_ON_MS_3 / `ISBC_TICK_MS;
	localparam [31:0] DARK_T1 = `ISBC_OFF_MS_1 / `ISBC_TICK_MS;
	localparam [31:0] DARK_T2 = `ISBC_OFF_MS_2 / `ISBC_TICK_MS;
	localparam [31:0] DARK_T3 = `ISBC_OFF_MS_3 / `ISBC_TICK_MS;

	function [CNT_W-1:0] on_ticks;
		input [1:0] code;
		begin
			case (code)
				2'b00:   on_ticks = ON_T0[CNT_W-1:0];
				2'b01:   on_ticks = ON_T1[CNT_W-1:0];
				2'b10:   on_ticks = ON_T2[CNT_W-1:0];
				default: on_ticks = ON_T3[CNT_W-1:0];
			endcase
		end
	endfunction

	function [CNT_W-1:0] dark_ticks;
		input [1:0] code;
		begin
			case (code)
				2'b01:   dark_ticks = DARK_T1[CNT_W-1:0];
				2'b10:   dark_ticks = DARK_T2[CNT_W-1:0];
				default: dark_ticks = DARK_T3[CNT_W-1:0];
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// Phase state machine
	// ----------------------------------------------------------------
	localparam ST_IDLE = 2'b00;
	localparam ST_ON   = 2'b01;
	localparam ST_DARK = 2'b10;

	reg [1:0]       state_r;
	reg [CNT_W-1:0] count_r;

	always @(posedge clock or posedge reset) begin
		if (reset) begin
			state_r <= ST_IDLE;
			count_r <= {CNT_W{1'b0}};
			lit_r   <= 1'b0;
		end else if (clk_en) begin
			if (!enable) begin
				state_r <= ST_IDLE;
				lit_r   <= 1'b0;
			end else if (restart || state_r == ST_IDLE) begin
				state_r <= ST_ON;
				count_r <= on_ticks(on_code);
				lit_r   <= 1'b1;
			end else begin
				case (state_r)
					ST_ON: begin
						if (dark_code == 2'b00) begin
							lit_r <= 1'b1;
						end else if (tick) begin
							if (count_r <= 1) begin
								state_r <= ST_DARK;
								count_r <= dark_ticks(dark_code);
								lit_r   <= 1'b0;
							end else begin
								count_r <= count_r - 1'b1;
							end
						end
					end
					ST_DARK: begin
						if (dark_code == 2'b00) begin
							state_r <= ST_ON;
							count_r <= on_ticks(on_code);
							lit_r   <= 1'b1;
						end else if (tick) begin
							if (count_r <= 1) begin
								state_r <= ST_ON;
								count_r <= on_ticks(on_code);
								lit_r   <= 1'b1;
							end else begin
								count_r <= count_r - 1'b1;
							end
						end
					end
					default: begin
						state_r <= ST_IDLE;
						lit_r   <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule // isbc_sink_timer

`default_nettype wire

// ---- hw/isbc_top.v ----
/*
 Independent sink blink control: registers for fade law, sink enables
 and blink times, plus seven per-sink blink timers.
 Assumes the serial port front end delivers byte writes and reads as
 same-clock strobes with address and data.
*/
// How it works
// - The fade law field in bits 1:0 picks linear, square or two cubic transfer laws.
// - The enable register holds one on bit per sink, bit 0 for sink 1 to bit 6 for sink 7, bit 7 reserved.
// - Bits 7:6 of the upper time register pick an on time of 0.2, 0.6, 0.8 or 1.2 s.
// - The on time applies only to an enabled sink whose dark time is not disabled, then the sink goes dark.
// - Sinks 7, 6, 5 take dark time codes from bits 5:4, 3:2, 1:0: disabled, 0.6, 1.2 or 1.8 s.
// - An enabled sink with dark code 00 stays on without blinking.
// - With a nonzero dark code the sink alternates dark period and shared on period.
// - Sinks enabled in one write start their sequences together.
// - Sinks 4 to 1 take dark codes from bits 7:6 to 1:0 of the lower time register.
`timescale 1ns/1ps
`default_nettype none
`include "isbc_consts.vh"

module isbc_top #(
	parameter TICK_CYCLES = `ISBC_TICK_CYCLES
) (
	input  wire       clock,
	input  wire       reset,
	input  wire       clk_en,
	input  wire       reg_wr,
	input  wire       reg_rd,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	output reg  [7:0] reg_rdata,
	output reg  [1:0] sink_fade_law,
	output reg  [6:0] sink_lit
);

	localparam NSINK = `ISBC_SINK_COUNT;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	reg [1:0] fade_law_r;
	reg [6:0] sink_on_r;
	reg [7:0] time_upper_r;
	reg [7:0] time_lower_r;
	reg [6:0] start_r;
	reg [31:0] tick_cnt_r;
	reg        tick_r;

	wire [13:0] dark_codes = {time_upper_r[5:0], time_lower_r};
	wire [1:0]  blink_on_time = time_upper_r[7:6];
	wire [6:0]  lit_w;

	always @(posedge clock or posedge reset) begin
		if (reset) begin
			fade_law_r   <= 2'b00;
			sink_on_r    <= 7'h00;
			time_upper_r <= `ISBC_RESET_VALUE;
			time_lower_r <= `ISBC_RESET_VALUE;
			start_r      <= 7'h00;
		end else if (clk_en) begin
			start_r <= 7'h00;
			if (reg_wr) begin
				case (reg_addr)
					`ISBC_ADDR_FADE_LAW:
						fade_law_r <= reg_wdata[1:0];
					`ISBC_ADDR_SINK_ENABLE: begin
						sink_on_r <= reg_wdata[6:0];
						start_r   <= reg_wdata[6:0] & ~sink_on_r;
					end
					`ISBC_ADDR_TIME_UPPER:
						time_upper_r <= reg_wdata;
					`ISBC_ADDR_TIME_LOWER:
						time_lower_r <= reg_wdata;
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Read port and outputs
	// ----------------------------------------------------------------
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			reg_rdata     <= 8'h00;
			sink_fade_law <= 2'b00;
			sink_lit      <= 7'h00;
		end else if (clk_en) begin
			sink_fade_law <= fade_law_r;
			sink_lit      <= lit_w & sink_on_r;
			if (reg_rd) begin
				case (reg_addr)
					`ISBC_ADDR_FADE_LAW:    reg_rdata <= {6'h00, fade_law_r};
					`ISBC_ADDR_SINK_ENABLE: reg_rdata <= {1'b0, sink_on_r};
					`ISBC_ADDR_TIME_UPPER:  reg_rdata <= time_upper_r;
					`ISBC_ADDR_TIME_LOWER:  reg_rdata <= time_lower_r;
					default:                reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Time base
	// ----------------------------------------------------------------
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			tick_cnt_r <= 32'h0000_0000;
			tick_r     <= 1'b0;
		end else if (clk_en) begin
			if (tick_cnt_r >= TICK_CYCLES - 1) begin
				tick_cnt_r <= 32'h0000_0000;
				tick_r     <= 1'b1;
			end else begin
				tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
				tick_r     <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Per-sink timers
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NSINK; g = g + 1) begin : g_sink
			isbc_sink_timer u_timer (
				.clock     (clock),
				.reset     (reset),
				.clk_en    (clk_en),
				.tick      (tick_r),
				.enable    (sink_on_r[g]),
				.restart   (start_r[g]),
				.on_code   (blink_on_time),
				.dark_code (dark_codes[2*g+1:2*g]),
				.lit_r     (lit_w[g])
			);
		end
	endgenerate

endmodule // isbc_top

`default_nettype wire

// ---- bench/isbc_chk.sv ----
/*
 Port checker for isbc_top.
 Assumes binding to isbc_top and clk_en held high.
*/
`timescale 1ns/1ps
`default_nettype none
module isbc_chk #(
	parameter TICK_CYCLES = 2
) (
	input wire logic       clock,
	input wire logic       reset,
	input wire logic       clk_en,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic [1:0] sink_fade_law,
	input wire logic [6:0] sink_lit
);
	// ----
	// Shadow enables and sink 1 lit count
	// ----
	logic [6:0]  en_r;
	logic [15:0] cnt_r;
	wire  [7:0]  rise = {1'b0, reg_wdata[6:0] & ~en_r};
	wire         en_wr = clk_en && reg_wr && reg_addr == 8'h10;
	always @(posedge clock or posedge reset) begin
		if (reset) begin
			en_r <= 7'h00;
			cnt_r <= 16'h0000;
		end else begin
			if (en_wr)
				en_r <= reg_wdata[6:0];
			cnt_r <= sink_lit[0] ? cnt_r + 16'h0001 : 16'h0000;
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	chk_rdata_hold: assert property (
		!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
	chk_law_copy: assert property (
		clk_en && reg_wr && reg_addr == 8'h0F |-> ##2
		{6'h00, sink_fade_law} == ($past(reg_wdata, 2) & 8'h03))
		else $error("fade law output wrong");
	chk_rd_unmapped: assert property (
		reg_rd && (reg_addr < 8'h0F || reg_addr > 8'h12) |=>
		reg_rdata == 8'h00) else $error("unmapped read not zero");
	chk_law_reserved: assert property (
		reg_rd && reg_addr == 8'h0F |=> reg_rdata[7:2] == 6'h00)
		else $error("reserved law bits set");
	chk_disable_off: assert property (
		en_wr |-> ##3 (({1'b0, sink_lit} & ~$past(reg_wdata, 3)) == 8'h00))
		else $error("disabled sink still lit");
	chk_enable_lights: assert property (
		en_wr |-> ##3 (({1'b0, sink_lit} & $past(rise, 3)) == $past(rise, 3)))
		else $error("enabled sinks not lit together");
	chk_lit_needs_en: assert property (
		((sink_lit & ~$past(sink_lit)) & ~en_r) == 7'h00)
		else $error("sink lit while disabled");
	chk_on_phase_min: assert property (
		$fell(sink_lit[0]) && en_r[0] |-> cnt_r >= 199 * TICK_CYCLES - 2)
		else $error("on phase too short");
	cover property ($fell(sink_lit[0]) && en_r[0]);
	cover property (reg_rd && reg_addr == 8'h13);
	cover property (sink_lit == 7'h7F);
endmodule // isbc_chk

bind isbc_top isbc_chk #(.TICK_CYCLES(TICK_CYCLES)) i_isbc_chk (
	.clock(clock), .reset(reset), .clk_en(clk_en), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .sink_fade_law(sink_fade_law),
	.sink_lit(sink_lit));
`default_nettype wire

// ---- bench/tb_top.sv ----
/*
 Bench for isbc_top: register access and blink timing.
 Assumes isbc_chk is bound to the design.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ----
	// Stimulus and helpers
	// ----
	localparam T = 2;
	logic       clock = 0, reset = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	logic [1:0] d;
	wire  [7:0] reg_rdata;
	wire  [1:0] sink_fade_law;
	wire  [6:0] sink_lit;
	int err_count = 0, tests_run = 0, cyc = 0, n;
	int on_ms[4] = '{200, 600, 800, 1200};
	int off_ms[4] = '{0, 600, 1200, 1800};
	logic [7:0] ad[5] = '{8'h20, 8'h0F, 8'h11, 8'h12, 8'h10};
	logic [7:0] wd[5] = '{8'hFF, 8'hFF, 8'hA5, 8'h5A, 8'hFF};
	logic [7:0] ex[5] = '{8'h00, 8'h03, 8'hA5, 8'h5A, 8'h7F};
	isbc_top #(.TICK_CYCLES(T)) i_isbc_top (.clock(clock), .reset(reset),
		.clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.sink_fade_law(sink_fade_law), .sink_lit(sink_lit));
	always #5 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			conclude;
		end
	end
	task conclude;
		if (err_count == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task cmp(string nm, logic [15:0] e, logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s exp %h got %h", nm, e, g);
		end
	endtask
	task near(string nm, int e, int g);
		tests_run++;
		if (g < e - T - 3 || g > e + T + 3) begin
			err_count++;
			$display("ERROR %s exp %0d got %0d", nm, e, g);
		end
	endtask
	task tk(int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	task wr(logic [7:0] a, logic [7:0] v);
		reg_addr = a;
		reg_wdata = v;
		reg_wr = 1;
		tk(1);
		reg_wr = 0;
		tk(1);
	endtask
	task rd(logic [7:0] a, logic [7:0] e);
		reg_addr = a;
		reg_rd = 1;
		tk(1);
		reg_rd = 0;
		cmp("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
		tk(1);
	endtask
	task meas(int k, logic lv, output int c);
		c = 0;
		while (sink_lit[k] === lv && c < 9000) begin
			tk(1);
			c++;
		end
	endtask
	// ----
	// Test sequence
	// ----
	initial begin
		tk(8);
		reset = 0;
		for (int a = 14; a < 20; a++) rd(a[7:0], 8'h00);
		for (int i = 0; i < 5; i++) begin
			wr(ad[i], wd[i]);
			rd(ad[i], ex[i]);
		end
		wr(8'h10, 8'h00);
		for (int l = 0; l < 4; l++) begin
			wr(8'h0F, l[7:0]);
			tk(1);
			cmp("sink_fade_law", l[15:0], {14'h0000, sink_fade_law});
		end
		wr(8'h11, 8'h00);
		wr(8'h12, 8'h00);
		wr(8'h10, 8'h7F);
		tk(2);
		cmp("sink_lit", 16'h007F, {9'h000, sink_lit});
		tk(3000);
		cmp("sink_lit", 16'h007F, {9'h000, sink_lit});
		wr(8'h10, 8'h00);
		tk(2);
		cmp("sink_lit", 16'h0000, {9'h000, sink_lit});
		for (int i = 0; i < 7; i++) begin
			wr(8'h11, i > 3 ? 8'h01 << (2 * (i - 4)) : 8'h00);
			wr(8'h12, i < 4 ? 8'h01 << (2 * i) : 8'h00);
			wr(8'h10, 8'h7F);
			tk(2 + 202 * T);
			cmp("sink_lit", 16'h007F & ~(16'h0001 << i), {9'h000, sink_lit});
			wr(8'h10, 8'h00);
		end
		for (int i = 0; i < 4; i++) begin
			d = i % 3 + 1;
			wr(8'h11, {i[1:0], d, d, d});
			wr(8'h12, {4{d}});
			wr(8'h10, 8'h7F);
			tk(2);
			meas(0, 1, n);
			near("on_len", on_ms[i] * T, n);
			cmp("sink_lit", 16'h0000, {9'h000, sink_lit});
			meas(0, 0, n);
			near("dark_len", off_ms[d] * T, n);
			cmp("sink_lit", 16'h007F, {9'h000, sink_lit});
			meas(6, 1, n);
			near("on_len", on_ms[i] * T, n);
			wr(8'h10, 8'h00);
		end
		conclude;
	end
endmodule // tb_top
`default_nettype wire
